// >>> bmdvs_buck_control.sv
// mode, set point and voltage ramp control for one buck regulator
`timescale 1ns/1ps
`include "bmdvs_defs.svh"
// ----------------------------------------------------------------
// How it works
// - overcurrent limits current each switching cycle; regulator stays on
// - limit held continuously beyond 8.0 ms raises fault interrupt
// - style changes on code write, standby, sleep, and load in auto
// - off style stops switching and discharges the output
// - auto style follows load between skip and PWM; others stay fixed
// - soft start walks pfm, auto, pwm; 3.0 ms later selected style
// - four-bit code decodes to normal and standby styles
// - standby uses standby set point and style; leaving restores normal
// - normal and standby set points share one code range
// - turn-off with retain bit set enters sleep: sleep set point, pfm
// - turn-off with retain bit clear switches regulator off
// - turn-on from sleep with retain: stays on, goes to normal settings
// - turn-on without retain: start at slot with default settings
// - group one sleep set point six bits, others seven bits
// - normal set point drives output; written changes ramp at rate
// - standby input low picks normal, high picks standby set point
// - standby and sleep transitions ramp at the programmed rate
// - group one: 25 mV step every 2, 4, 8, 16 us; default 01
// - others: top bit set gives 50 mV every 4 to 32 us
// - turn-off: level button low, or switch held low over 4 s
// ----------------------------------------------------------------
module bmdvs_buck_control
	import bmdvs_pkg::*;
#(
	parameter bit GROUP_ONE      = 1'b0,
	parameter int OC_FAULT_CYC   = `BMDVS_OC_FAULT_CYC,
	parameter int SETTLE_CYC     = `BMDVS_SETTLE_CYC,
	parameter int LONG_PRESS_CYC = `BMDVS_LONG_PRESS_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  bmdvs_cfg_t      cfg,
	input  wire logic       standby,
	input  wire logic       power_button_input,
	input  wire logic       power_button_style,
	input  wire logic       long_press_off_enable,
	input  wire logic       turnOn,
	input  wire logic       startSlot,
	input  wire logic       currentLimit,
	input  wire logic       heavyLoad,
	output bmdvs_out_t      regOut,
	output logic            cycleLimit,
	output logic            ocFault,
	output logic            turnOffEvent,
	output logic            codeReserved
);

	localparam int SP_W = `BMDVS_SP_WIDTH;

	// ------------------------------------------------------------
	// decode and set point selection
	// ------------------------------------------------------------
	bmdvs_style_t normalStyle;
	bmdvs_style_t standbyStyle;
	logic [SP_W-1:0] spMask;
	logic [SP_W-1:0] targetSp;
	logic [SP_W-1:0] level;
	logic            ramping;
	logic            rampLoad;
	logic [SP_W-1:0] rampLoadValue;
	logic            wideStep;

	bmdvs_style_decode u_decode (
		.code         (cfg.styleCode),
		.normalStyle  (normalStyle),
		.standbyStyle (standbyStyle),
		.reserved     (codeReserved)
	);

	bmdvs_state_t state_q;

	// group one set points are six bits wide
	assign spMask = GROUP_ONE ? 7'h3f : 7'h7f;

	always_comb begin
		if (state_q == ST_SLEEP) begin
			targetSp = cfg.sleepSp & spMask;
		end else if (standby) begin
			targetSp = cfg.standbySp & spMask;
		end else begin
			targetSp = cfg.normalSp & spMask;
		end
	end

	// wide steps only for the seven-bit group, keyed on target top bit
	assign wideStep = !GROUP_ONE && targetSp[`BMDVS_SP_TOP_BIT];

	bmdvs_ramp #(
		.SP_W     (SP_W),
		.BASE_CYC (`BMDVS_STEP_BASE_CYC)
	) u_ramp (
		.clk       (clk),
		.rst_n     (rst_n),
		.load      (rampLoad),
		.loadValue (rampLoadValue),
		.target    (targetSp),
		.rate      (cfg.rampRate),
		.wideStep  (wideStep),
		.level     (level),
		.ramping   (ramping)
	);

	// ------------------------------------------------------------
	// power button turn-off detection
	// ------------------------------------------------------------
	logic [31:0] press_q;
	logic        longPress;
	logic        buttonLow_q;
	logic        levelOff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			press_q <= '0;
		end else if (power_button_input) begin
			press_q <= '0;
		end else if (press_q != 32'(LONG_PRESS_CYC)) begin
			press_q <= press_q + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			buttonLow_q <= 1'b0;
		end else begin
			buttonLow_q <= !power_button_input;
		end
	end

	assign longPress = (press_q == 32'(LONG_PRESS_CYC) - 32'h1);
	assign levelOff  = !power_button_style && !power_button_input && !buttonLow_q;
	assign turnOffEvent = levelOff
		|| (power_button_style && long_press_off_enable && longPress);

	// ------------------------------------------------------------
	// regulator state machine
	// ------------------------------------------------------------
	logic [31:0] settle_q;
	logic        settled;

	assign settled = (settle_q == 32'(SETTLE_CYC));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_START;
		end else begin
			case (state_q)
				ST_OFF: begin
					if (turnOn && startSlot) begin
						state_q <= ST_START;
					end
				end
				ST_START: begin
					if (turnOffEvent) begin
						state_q <= cfg.sleepRetain ? ST_SLEEP : ST_OFF;
					end else if (!ramping) begin
						state_q <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					if (turnOffEvent) begin
						state_q <= cfg.sleepRetain ? ST_SLEEP : ST_OFF;
					end else if (settled) begin
						state_q <= ST_ON;
					end
				end
				ST_ON: begin
					if (turnOffEvent && cfg.sleepRetain) begin
						state_q <= ST_SLEEP;
					end else if (turnOffEvent) begin
						state_q <= ST_OFF;
					end
				end
				ST_SLEEP: begin
					if (turnOn) begin
						state_q <= ST_ON;
					end
				end
				default: begin
					state_q <= ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			settle_q <= '0;
		end else if (state_q != ST_SETTLE) begin
			settle_q <= '0;
		end else if (!settled) begin
			settle_q <= settle_q + 32'h1;
		end
	end

	// starting up from off reloads the default level; sleep exit does not
	assign rampLoad      = (state_q == ST_OFF);
	assign rampLoadValue = cfg.defaultSp & spMask;

	// ------------------------------------------------------------
	// switching style selection
	// ------------------------------------------------------------
	bmdvs_style_t style;
	logic [1:0]   startPhase;

	// soft start walks the three styles: pfm below half the target, auto until the target is reached, then pwm
	assign startPhase = (level < (targetSp >> 1)) ? 2'h0 : (ramping ? 2'h1 : 2'h2);

	always_comb begin
		case (state_q)
			ST_OFF: begin
				style = STYLE_OFF;
			end
			ST_START, ST_SETTLE: begin
				if (state_q == ST_SETTLE || startPhase == 2'h2) begin
					style = STYLE_PWM;
				end else if (startPhase == 2'h1) begin
					style = STYLE_AUTO;
				end else begin
					style = STYLE_PFM;
				end
			end
			ST_SLEEP: begin
				style = STYLE_PFM;
			end
			ST_ON: begin
				style = standby ? standbyStyle : normalStyle;
			end
			default: begin
				style = STYLE_OFF;
			end
		endcase
	end

	// ------------------------------------------------------------
	// output stage and overcurrent timing
	// ------------------------------------------------------------
	bmdvs_style_t effStyle;
	logic [31:0]  oc_q;

	always_comb begin
		effStyle = style;
		if (style == STYLE_AUTO) begin
			effStyle = heavyLoad ? STYLE_PWM : STYLE_SKIP;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regOut <= '{STYLE_OFF, 7'h00, 1'b1, 1'b0, 1'b0};
		end else begin
			regOut.style      <= effStyle;
			regOut.setpoint   <= level;
			regOut.discharge  <= (effStyle == STYLE_OFF);
			regOut.ramping    <= ramping;
			regOut.regulating <= (effStyle != STYLE_OFF);
		end
	end

	// limit is applied per switching cycle, regulator never shut down
	assign cycleLimit = currentLimit && (effStyle != STYLE_OFF);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			oc_q <= '0;
		end else if (!cycleLimit) begin
			oc_q <= '0;
		end else if (oc_q != 32'(OC_FAULT_CYC)) begin
			oc_q <= oc_q + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ocFault <= 1'b0;
		end else begin
			ocFault <= (oc_q == 32'(OC_FAULT_CYC) - 32'h1);
		end
	end

endmodule

// >>> bmdvs_buck_control_asserts.sv
// concurrent checks on the ports of one buck regulator control
`timescale 1ns/1ps
module bmdvs_buck_control_asserts
	import bmdvs_pkg::*;
#(
	parameter int OC_FAULT_CYC = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input bmdvs_cfg_t      cfg,
	input wire logic power_button_input,
	input wire logic power_button_style,
	input wire logic currentLimit,
	input bmdvs_out_t      regOut,
	input wire logic cycleLimit,
	input wire logic ocFault,
	input wire logic turnOffEvent,
	input wire logic codeReserved
);
	logic [15:0] limRun_q;
	logic [8:0]  gap_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// run length of the limit flag
	always_ff @(posedge clk) begin
		if (!rst_n || !currentLimit) limRun_q <= 16'h0;
		else if (limRun_q != 16'hffff) limRun_q <= limRun_q + 16'h1;
	end

	// cycles since the last set point step
	always_ff @(posedge clk) begin
		if (!rst_n || $changed(regOut.setpoint)) gap_q <= 9'h0;
		else if (gap_q != 9'h1ff) gap_q <= gap_q + 9'h1;
	end

	chk_off_discharge: assert property (regOut.style == STYLE_OFF |-> regOut.discharge)
		else $error("off without discharge");
	chk_limit_source: assert property (cycleLimit |-> currentLimit)
		else $error("cycle limit without cause");
	chk_fault_delay: assert property (ocFault |-> limRun_q >= OC_FAULT_CYC - 2)
		else $error("fault too early");
	chk_fault_pulse: assert property (ocFault |=> !ocFault)
		else $error("fault longer than one cycle");
	chk_code_reserved: assert property (
		codeReserved == (cfg.styleCode inside {4'h2, 4'h7, 4'h9, 4'ha, 4'hb, 4'he, 4'hf}))
		else $error("reserved flag wrong");
	chk_level_off: assert property (
		!power_button_style && $fell(power_button_input) |-> turnOffEvent)
		else $error("no turn off on low level");
	chk_press_low: assert property (turnOffEvent |-> !power_button_input)
		else $error("turn off with button high");
	chk_ramp_single: assert property (
		$changed(regOut.setpoint) && $past(regOut.ramping) |->
		regOut.setpoint == $past(regOut.setpoint) + 7'h1 ||
		regOut.setpoint == $past(regOut.setpoint) - 7'h1)
		else $error("ramp step not one code");
	chk_step_gap: assert property (
		$changed(regOut.setpoint) && $past(regOut.ramping) |-> gap_q >= 9'h0c7)
		else $error("ramp step too soon");

	cover property (ocFault);
	cover property ($fell(regOut.ramping));
	cover property (turnOffEvent);
endmodule

bind bmdvs_buck_control bmdvs_buck_control_asserts #(.OC_FAULT_CYC(OC_FAULT_CYC)) u_chk (
	.clk, .rst_n, .cfg, .power_button_input, .power_button_style, .currentLimit,
	.regOut, .cycleLimit, .ocFault, .turnOffEvent, .codeReserved);

// >>> bmdvs_buck_control_tb.sv
// self-checking bench for one buck regulator control
`timescale 1ns/1ps
module bmdvs_buck_control_tb
	import bmdvs_pkg::*;
;
	logic       clk, rst_n, standby, btnIn, btnSw, lpEn, turnOn, startSlot;
	logic       go, heavy, currentLimit, heavyLoad;
	logic       cycleLimit, ocFault, turnOffEvent, codeReserved;
	logic [7:0] burst;
	bmdvs_cfg_t cfg;
	bmdvs_out_t regOut;
	int         bad_count, check_count, faults, offs;
	logic [3:0] codes [8] = '{4'h5, 4'h6, 4'h8, 4'hc, 4'hd, 4'h1, 4'h3, 4'h4};
	bmdvs_style_t nExp [8] = '{STYLE_PWM, STYLE_PWM, STYLE_SKIP, STYLE_SKIP,
		STYLE_PWM, STYLE_PWM, STYLE_PFM, STYLE_SKIP};
	bmdvs_style_t sExp [5] = '{STYLE_PWM, STYLE_SKIP, STYLE_SKIP, STYLE_PFM, STYLE_PFM};

	bmdvs_buck_control #(.OC_FAULT_CYC(20), .SETTLE_CYC(10), .LONG_PRESS_CYC(30))
		bmdvs_buck_control_inst (.clk, .rst_n, .cfg, .standby,
		.power_button_input(btnIn), .power_button_style(btnSw),
		.long_press_off_enable(lpEn), .turnOn, .startSlot, .currentLimit,
		.heavyLoad, .regOut, .cycleLimit, .ocFault, .turnOffEvent, .codeReserved);
	bmdvs_load_model bmdvs_load_model_inst (.clk, .go, .burst, .heavy,
		.currentLimit, .heavyLoad);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (ocFault === 1'b1) faults++;
		if (turnOffEvent === 1'b1) offs++;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#500000;
		bad_count++;
		conclude();
	end

	initial begin
		rst_n = 0; standby = 0; btnIn = 1; btnSw = 0; lpEn = 0;
		turnOn = 0; startSlot = 0; go = 0; heavy = 0; burst = 8'h28;
		cfg = '{styleCode: 4'h8, sleepRetain: 1'b1, rampRate: 2'h0, normalSp: 7'h3,
			standbySp: 7'h3, sleepSp: 7'h2, defaultSp: 7'h3};
		wt(5);
		chk(regOut.style, STYLE_OFF);
		chk(regOut.discharge, 1'b1);
		chk(regOut.regulating, 1'b0);
		rst_n = 1;
		wt(900);
		chk(regOut.setpoint, 7'h3);
		chk(regOut.style, STYLE_SKIP);
		chk(regOut.regulating, 1'b1);
		heavy = 1;
		wt(3);
		chk(regOut.style, STYLE_PWM);
		heavy = 0;
		cfg.rampRate = 2'h1;
		cfg.normalSp = 7'h5;
		wt(300);
		chk(regOut.setpoint, 7'h3);
		chk(regOut.ramping, 1'b1);
		wt(600);
		chk(regOut.setpoint, 7'h5);
		chk(regOut.ramping, 1'b0);
		cfg.standbySp = 7'h4;
		standby = 1;
		wt(300);
		chk(regOut.setpoint, 7'h5);
		wt(150);
		chk(regOut.setpoint, 7'h4);
		standby = 0;
		wt(450);
		chk(regOut.setpoint, 7'h5);
		go = 1;
		wt(1);
		go = 0;
		wt(3);
		chk(cycleLimit, 1'b1);
		chk(regOut.style, STYLE_SKIP);
		wt(13);
		chk(faults[7:0], 8'h0);
		wt(30);
		chk(faults[7:0], 8'h1);
		btnIn = 0;
		wt(3);
		chk(offs[7:0], 8'h1);
		chk(regOut.style, STYLE_PFM);
		wt(1300);
		chk(regOut.setpoint, 7'h2);
		btnIn = 1;
		turnOn = 1;
		wt(1);
		turnOn = 0;
		wt(3);
		chk(regOut.style, STYLE_SKIP);
		chk(regOut.discharge, 1'b0);
		wt(1300);
		chk(regOut.setpoint, 7'h5);
		cfg.sleepRetain = 0;
		btnIn = 0;
		wt(3);
		chk(regOut.style, STYLE_OFF);
		chk(regOut.discharge, 1'b1);
		chk(regOut.regulating, 1'b0);
		btnIn = 1;
		wt(2);
		btnSw = 1;
		lpEn = 1;
		btnIn = 0;
		wt(25);
		chk(offs[7:0], 8'h2);
		wt(10);
		chk(offs[7:0], 8'h3);
		btnIn = 1;
		wt(2);
		btnSw = 0;
		turnOn = 1;
		startSlot = 1;
		wt(1);
		turnOn = 0;
		startSlot = 0;
		wt(3000);
		chk(regOut.style, STYLE_SKIP);
		chk(regOut.setpoint, 7'h5);
		for (int i = 0; i < 8; i++) begin
			cfg.styleCode = codes[i];
			standby = 0;
			wt(3);
			chk(regOut.style, nExp[i]);
			if (i < 5) begin
				standby = 1;
				wt(3);
				chk(regOut.style, sExp[i]);
			end
		end
		standby = 1;
		wt(3);
		chk(regOut.style, STYLE_OFF);
		for (int c = 0; c < 16; c++) begin
			cfg.styleCode = c[3:0];
			wt(1);
			chk(codeReserved, c inside {2, 7, 9, 10, 11, 14, 15});
		end
		conclude();
	end
endmodule

// >>> bmdvs_defs.svh
// constants for the buck mode and voltage ramp control
`ifndef BMDVS_DEFS_SVH
`define BMDVS_DEFS_SVH

`define BMDVS_CLK_HZ          100000000
`define BMDVS_OC_FAULT_US     8000
`define BMDVS_OC_FAULT_CYC    ((`BMDVS_OC_FAULT_US * (`BMDVS_CLK_HZ / 1000000)) + 1)
`define BMDVS_SETTLE_US       3000
`define BMDVS_SETTLE_CYC      (`BMDVS_SETTLE_US * (`BMDVS_CLK_HZ / 1000000))
`define BMDVS_LONG_PRESS_MS   4000
`define BMDVS_LONG_PRESS_CYC  ((`BMDVS_LONG_PRESS_MS * (`BMDVS_CLK_HZ / 1000)) + 1)
`define BMDVS_STEP_BASE_NS    2000
`define BMDVS_STEP_BASE_CYC   (`BMDVS_STEP_BASE_NS / (1000000000 / `BMDVS_CLK_HZ))
`define BMDVS_CODE_RESET      4'h8
`define BMDVS_RATE_RESET      2'h1
`define BMDVS_SP_WIDTH        7
`define BMDVS_SP_TOP_BIT      6

`endif

// >>> bmdvs_load_model.sv
// load side model: overcurrent bursts and load level
`timescale 1ns/1ps
module bmdvs_load_model (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [7:0] burst,
	input  wire logic       heavy,
	output logic            currentLimit,
	output logic            heavyLoad
);
	logic [7:0] left_q;

	initial left_q = 8'h0;
	// limit flag held for a commanded run
	always_ff @(posedge clk) begin
		if (go) left_q <= burst;
		else if (left_q != 8'h0) left_q <= left_q - 8'h1;
	end
	assign currentLimit = (left_q != 8'h0);
	assign heavyLoad    = heavy;
endmodule

// >>> bmdvs_pkg.sv
// types for the buck mode and voltage ramp control
package bmdvs_pkg;

	typedef enum logic [2:0] {
		STYLE_OFF  = 3'h0,
		STYLE_PFM  = 3'h1,
		STYLE_AUTO = 3'h2,
		STYLE_PWM  = 3'h3,
		STYLE_SKIP = 3'h4
	} bmdvs_style_t;

	typedef enum logic [2:0] {
		ST_OFF    = 3'h0,
		ST_START  = 3'h1,
		ST_SETTLE = 3'h2,
		ST_ON     = 3'h3,
		ST_SLEEP  = 3'h4
	} bmdvs_state_t;

	typedef struct packed {
		logic [3:0] styleCode;
		logic       sleepRetain;
		logic [1:0] rampRate;
		logic [6:0] normalSp;
		logic [6:0] standbySp;
		logic [6:0] sleepSp;
		logic [6:0] defaultSp;
	} bmdvs_cfg_t;

	typedef struct packed {
		bmdvs_style_t style;
		logic [6:0]   setpoint;
		logic         discharge;
		logic         ramping;
		logic         regulating;
	} bmdvs_out_t;

endpackage

// >>> bmdvs_ramp.sv
// moves a set point one code per interval toward its target
`timescale 1ns/1ps
module bmdvs_ramp
	import bmdvs_pkg::*;
#(
	parameter int SP_W     = 7,
	parameter int BASE_CYC = 200
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            load,
	input  wire logic [SP_W-1:0] loadValue,
	input  wire logic [SP_W-1:0] target,
	input  wire logic [1:0]      rate,
	input  wire logic            wideStep,
	output logic      [SP_W-1:0] level,
	output logic                 ramping
);

	localparam int CNT_W = 14;

	logic [SP_W-1:0]  level_q;
	logic [CNT_W-1:0] tick_q;
	logic [CNT_W-1:0] interval;

	// interval doubles per rate code; wide steps double again
	always_comb begin
		interval = CNT_W'(BASE_CYC) << ({1'b0, rate} + {2'b00, wideStep});
	end

	assign ramping = (level_q != target);
	assign level   = level_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_q <= '0;
		end else if (load || !ramping || tick_q == interval - CNT_W'(1)) begin
			tick_q <= '0;
		end else begin
			tick_q <= tick_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_q <= '0;
		end else if (load) begin
			level_q <= loadValue;
		end else if (ramping && tick_q == interval - CNT_W'(1)) begin
			if (level_q < target) begin
				level_q <= level_q + SP_W'(1);
			end else begin
				level_q <= level_q - SP_W'(1);
			end
		end
	end

endmodule

// >>> bmdvs_style_decode.sv
// decodes a four-bit style code into normal and standby styles
`timescale 1ns/1ps
module bmdvs_style_decode
	import bmdvs_pkg::*;
(
	input  wire logic [3:0] code,
	output bmdvs_style_t    normalStyle,
	output bmdvs_style_t    standbyStyle,
	output logic            reserved
);

	always_comb begin
		reserved = 1'b0;
		case (code)
			4'h0: begin normalStyle = STYLE_OFF;  standbyStyle = STYLE_OFF;  end
			4'h1: begin normalStyle = STYLE_PWM;  standbyStyle = STYLE_OFF;  end
			4'h3: begin normalStyle = STYLE_PFM;  standbyStyle = STYLE_OFF;  end
			4'h4: begin normalStyle = STYLE_AUTO; standbyStyle = STYLE_OFF;  end
			4'h5: begin normalStyle = STYLE_PWM;  standbyStyle = STYLE_PWM;  end
			4'h6: begin normalStyle = STYLE_PWM;  standbyStyle = STYLE_AUTO; end
			4'h8: begin normalStyle = STYLE_AUTO; standbyStyle = STYLE_AUTO; end
			4'hc: begin normalStyle = STYLE_AUTO; standbyStyle = STYLE_PFM;  end
			4'hd: begin normalStyle = STYLE_PWM;  standbyStyle = STYLE_PFM;  end
			default: begin
				normalStyle  = STYLE_OFF;
				standbyStyle = STYLE_OFF;
				reserved     = 1'b1;
			end
		endcase
	end

endmodule
